// [ibmcc_top.sv]
// Top: APB register file and two independent DMA command channels
//
// Functional notes
// - Reserved command bits read back as zero
// - Direction bit: zero reads memory, one writes
// - Only start bit rising edge begins operation
// - Data moves only while start bit set
// - Writing zero to start halts channel
// - Clearing start discards all transfer state
// - Early stop while active marks command aborted
// - Drive interrupt rise sets, write-one clears
//
// Chosen here: the APB slave port.
`timescale 1ns/1ns
module ibmcc_top (
  // Clock and reset
  input  wire logic        CLK_IN,
  input  wire logic        ARST_N_IN,
  // APB slave
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic [31:0]      PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  // Drive interrupt lines, index 0 primary, 1 secondary
  input  wire logic [1:0]  DRIVE_IRQ_IN,
  // Drive data request and acknowledge
  input  wire logic [1:0]  DRIVE_REQ_IN,
  output logic [1:0]       DRIVE_ACK_OUT,
  // Memory access strobes
  output logic [1:0]       MEM_RD_OUT,
  output logic [1:0]       MEM_WR_OUT,
  // Channel status
  output logic [1:0]       ACTIVE_OUT,
  output logic [1:0]       ABORT_OUT
);
  import ibmcc_pkg::*;

  logic [7:0]  cmd_r [IBMCC_NUM_CH];
  logic [1:0]  active;
  logic [1:0]  irq;
  logic [1:0]  abort;
  logic [1:0]  irq_clr;
  logic [15:0] count [IBMCC_NUM_CH];
  logic        wr_acc;
  logic [31:0] rdata_nxt;
  logic [31:0] prdata_r;
  logic        hit;

  // APB access phase, zero wait states
  assign wr_acc      = PSEL_IN & PENABLE_IN & PWRITE_IN;
  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~hit;
  assign PRDATA_OUT  = prdata_r;

  // Per-channel command register and engine
  genvar g;
  generate
    for (g = 0; g < IBMCC_NUM_CH; g++) begin : g_ch
      localparam logic [7:0] CMD_OFS  = (g == 0) ? IBMCC_PRI_CMD_OFS : IBMCC_SEC_CMD_OFS;
      localparam logic [7:0] STAT_OFS = (g == 0) ? IBMCC_PRI_STAT_OFS : IBMCC_SEC_STAT_OFS;

      // Command register write, masked to implemented bits
      always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
          cmd_r[g] <= IBMCC_CMD_RST;
        end else if (wr_acc && PADDR_IN == CMD_OFS) begin
          cmd_r[g] <= PWDATA_IN[7:0] & IBMCC_CMD_MASK;
        end
      end

      // Interrupt write-one-to-clear strobe
      assign irq_clr[g] = wr_acc & (PADDR_IN == STAT_OFS) & PWDATA_IN[IBMCC_IRQ_BIT];

      ibmcc_channel u_ch (
        .clk_in        (CLK_IN),
        .arst_n_in     (ARST_N_IN),
        .start_in      (cmd_r[g][IBMCC_START_BIT]),
        .dir_in        (cmd_r[g][IBMCC_DIR_BIT]),
        .drive_irq_in  (DRIVE_IRQ_IN[g]),
        .irq_clr_in    (irq_clr[g]),
        .drive_req_in  (DRIVE_REQ_IN[g]),
        .drive_ack_out (DRIVE_ACK_OUT[g]),
        .mem_rd_out    (MEM_RD_OUT[g]),
        .mem_wr_out    (MEM_WR_OUT[g]),
        .active_out    (active[g]),
        .irq_out       (irq[g]),
        .abort_out     (abort[g]),
        .count_out     (count[g])
      );
    end
  endgenerate

  assign ACTIVE_OUT = active;
  assign ABORT_OUT  = abort;

  // Read mux
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    hit       = 1'b1;
    case (PADDR_IN)
      IBMCC_PRI_CMD_OFS:  rdata_nxt[7:0] = cmd_r[0];
      IBMCC_SEC_CMD_OFS:  rdata_nxt[7:0] = cmd_r[1];
      IBMCC_PRI_STAT_OFS: begin
        rdata_nxt[31:16]            = count[0];
        rdata_nxt[IBMCC_IRQ_BIT]    = irq[0];
        rdata_nxt[IBMCC_ABORT_BIT]  = abort[0];
        rdata_nxt[IBMCC_ACTIVE_BIT] = active[0];
      end
      IBMCC_SEC_STAT_OFS: begin
        rdata_nxt[31:16]            = count[1];
        rdata_nxt[IBMCC_IRQ_BIT]    = irq[1];
        rdata_nxt[IBMCC_ABORT_BIT]  = abort[1];
        rdata_nxt[IBMCC_ACTIVE_BIT] = active[1];
      end
      default:            hit = 1'b0;
    endcase
  end

  // Read data captured in setup phase, valid during access
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      prdata_r <= 32'h0000_0000;
    end else if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
      prdata_r <= rdata_nxt;
    end
  end
endmodule // ibmcc_top

// [ibmcc_pkg.sv]
// Package: register map, field layout and states for the DMA command control block
package ibmcc_pkg;
  localparam logic [7:0] IBMCC_PRI_CMD_OFS   = 8'h00;  // primary_dma_command
  localparam logic [7:0] IBMCC_PRI_STAT_OFS  = 8'h04;  // Primary status (active, abort, interrupt, transfer count)
  localparam logic [7:0] IBMCC_SEC_CMD_OFS   = 8'h08;  // secondary_dma_command
  localparam logic [7:0] IBMCC_SEC_STAT_OFS  = 8'h0C;  // Secondary status
  localparam int         IBMCC_START_BIT     = 0;
  localparam int         IBMCC_DIR_BIT       = 3;
  localparam int         IBMCC_ACTIVE_BIT    = 0;
  localparam int         IBMCC_IRQ_BIT       = 2;
  localparam int         IBMCC_ABORT_BIT     = 1;
  localparam logic [7:0] IBMCC_CMD_RST       = 8'h00;
  localparam logic [7:0] IBMCC_CMD_MASK      = 8'h09;  // Only direction and start kept
  localparam logic [15:0] IBMCC_CNT_RST      = 16'h0000;
  localparam int         IBMCC_NUM_CH        = 2;
  typedef enum logic [1:0] {IBMCC_IDLE, IBMCC_RUN, IBMCC_DONE} ibmcc_state_t;
endpackage

// [ibmcc_channel.sv]
// One channel engine: start edge detect, transfer handshake, completion and abort
`timescale 1ns/1ns
module ibmcc_channel (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  // Command register bits
  input  wire logic        start_in,
  input  wire logic        dir_in,
  // Drive interrupt line and interrupt clear strobe
  input  wire logic        drive_irq_in,
  input  wire logic        irq_clr_in,
  // Drive data handshake
  input  wire logic        drive_req_in,
  output logic             drive_ack_out,
  // Memory side
  output logic             mem_rd_out,
  output logic             mem_wr_out,
  // Status
  output logic             active_out,
  output logic             irq_out,
  output logic             abort_out,
  output logic [15:0]      count_out
);
  import ibmcc_pkg::*;

  ibmcc_state_t state_r;
  logic         start_d_r;
  logic         irq_d_r;
  logic         irq_r;
  logic         abort_r;
  logic [15:0]  count_r;
  logic         start_rise;
  logic         xfer;

  // Edge detects and transfer qualifier
  assign start_rise = start_in & ~start_d_r;
  assign xfer       = (state_r == IBMCC_RUN) & start_in & drive_req_in;

  // Previous values for edge detection
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      start_d_r <= 1'b0;
      irq_d_r   <= 1'b0;
    end else begin
      start_d_r <= start_in;
      irq_d_r   <= drive_irq_in;
    end
  end

  // Engine state
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r <= IBMCC_IDLE;
    end else if (!start_in) begin
      state_r <= IBMCC_IDLE;
    end else begin
      case (state_r)
        IBMCC_IDLE: begin
          if (start_rise) begin
            state_r <= IBMCC_RUN;
          end
        end
        IBMCC_RUN: begin
          if (drive_irq_in & ~irq_d_r) begin
            state_r <= IBMCC_DONE;
          end
        end
        IBMCC_DONE: state_r <= IBMCC_DONE;
        default:    state_r <= IBMCC_IDLE;
      endcase
    end
  end

  // Transfer count, discarded on stop
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      count_r <= IBMCC_CNT_RST;
    end else if (!start_in || start_rise) begin
      count_r <= IBMCC_CNT_RST;
    end else if (xfer) begin
      count_r <= count_r + 16'h0001;
    end
  end

  // Interrupt status: edge sets, write-one clears, set wins
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_r <= 1'b0;
    end else if (drive_irq_in & ~irq_d_r) begin
      irq_r <= 1'b1;
    end else if (irq_clr_in) begin
      irq_r <= 1'b0;
    end
  end

  // Abort flag: stop while active and no interrupt yet
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      abort_r <= 1'b0;
    end else if (start_rise) begin
      abort_r <= 1'b0;
    end else if (!start_in && state_r == IBMCC_RUN && !irq_r) begin
      abort_r <= 1'b1;
    end
  end

  // Outputs
  assign drive_ack_out = xfer & ~abort_r;
  assign mem_rd_out    = xfer & ~dir_in;
  assign mem_wr_out    = xfer & dir_in;
  assign active_out    = (state_r == IBMCC_RUN);
  assign irq_out       = irq_r;
  assign abort_out     = abort_r;
  assign count_out     = count_r;
endmodule // ibmcc_channel

// [ibmcc_assertions.sv]
// Checker: command register and channel engine properties
`timescale 1ns/1ns
module ibmcc_assertions
  import ibmcc_pkg::*;
(
  // Clock, reset and APB
  input wire logic        CLK_IN, ARST_N_IN, PSEL_IN, PENABLE_IN, PWRITE_IN,
  input wire logic [7:0]  PADDR_IN,
  input wire logic [31:0] PWDATA_IN, PRDATA_OUT,
  // Channel pins
  input wire logic [1:0]  DRIVE_IRQ_IN, DRIVE_REQ_IN, DRIVE_ACK_OUT, MEM_RD_OUT, MEM_WR_OUT, ACTIVE_OUT, ABORT_OUT
);
  wire acc = PSEL_IN & PENABLE_IN;
  wire w0 = acc & PWRITE_IN & (PADDR_IN == IBMCC_PRI_CMD_OFS);
  wire w1 = acc & PWRITE_IN & (PADDR_IN == IBMCC_SEC_CMD_OFS);
  wire b0 = PWDATA_IN[IBMCC_START_BIT];
  logic [1:0] st_r;
  logic [1:0] dr_r;
  logic [1:0] iq_d_r;
  logic [1:0] iq_r;
  wire [1:0] iq_clr = {acc & PWRITE_IN & (PADDR_IN == IBMCC_SEC_STAT_OFS),
                       acc & PWRITE_IN & (PADDR_IN == IBMCC_PRI_STAT_OFS)} & {2{PWDATA_IN[IBMCC_IRQ_BIT]}};
  // Shadow of interrupt status: line rise sets, write-one clears, set wins
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      iq_d_r <= 2'h0;
      iq_r   <= 2'h0;
    end else begin
      iq_d_r <= DRIVE_IRQ_IN;
      iq_r   <= (DRIVE_IRQ_IN & ~iq_d_r) | (iq_r & ~iq_clr);
    end
  end
  // Shadow of start and direction bits
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      st_r <= 2'h0;
      dr_r <= 2'h0;
    end else begin
      if (w0) {dr_r[0], st_r[0]} <= {PWDATA_IN[IBMCC_DIR_BIT], b0};
      if (w1) {dr_r[1], st_r[1]} <= {PWDATA_IN[IBMCC_DIR_BIT], b0};
    end
  end
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  rsv_zero_a: assert property (acc && !PWRITE_IN && (PADDR_IN == 8'h00 || PADDR_IN == 8'h08) |->
    PRDATA_OUT[7:4] == 4'h0 && PRDATA_OUT[2:1] == 2'h0) else $error("reserved bits set");
  dir_sel_a: assert property ((MEM_RD_OUT & MEM_WR_OUT) == 2'h0 &&
    MEM_WR_OUT == ((MEM_RD_OUT | MEM_WR_OUT) & dr_r)) else $error("wrong direction");
  move_gate_a: assert property (((MEM_RD_OUT | MEM_WR_OUT | DRIVE_ACK_OUT) & ~(st_r & DRIVE_REQ_IN)) == 2'h0)
    else $error("transfer without start");
  start_rise_a: assert property (w0 && b0 && !st_r[0] && !DRIVE_IRQ_IN[0] |-> ##[1:2] ACTIVE_OUT[0])
    else $error("no start");
  no_restart_a: assert property (w0 && b0 && st_r[0] && !ACTIVE_OUT[0] |=> !ACTIVE_OUT[0] [*3])
    else $error("restarted");
  halt_chan_a: assert property (w0 && !b0 |-> ##2 !ACTIVE_OUT[0] [*2]) else $error("not halted");
  abort_set_a: assert property (w1 && !b0 && ACTIVE_OUT[1] && !DRIVE_IRQ_IN[1] && !iq_r[1] |-> ##2 ABORT_OUT[1])
    else $error("no abort");
  abort_clr_a: assert property (w1 && b0 && !st_r[1] |-> ##2 !ABORT_OUT[1]) else $error("stale abort");
  chan_iso_a: assert property (w1 |-> ##2 ABORT_OUT[0] == $past(ABORT_OUT[0], 2)) else $error("cross talk");
  irq_done_a: assert property ($rose(DRIVE_IRQ_IN[0]) && ACTIVE_OUT[0] |-> ##[1:2] !ACTIVE_OUT[0])
    else $error("still active");
  cover property (ABORT_OUT[1]);
  cover property (MEM_WR_OUT[0]);
  cover property (MEM_RD_OUT[1]);
endmodule // ibmcc_assertions

// [ibmcc_drive_model.sv]
// Partner: drive asking for a fixed beat count, then raising its interrupt
`timescale 1ns/1ns
module ibmcc_drive_model #(
  parameter int BEATS = 4  // Beats per command
) (
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  input  wire logic [1:0] go_in,
  input  wire logic [1:0] ack_in,
  output logic      [1:0] req_out,
  output logic      [1:0] irq_out
);
  logic [7:0] cnt_r [2];
  // Beats taken, cleared while the drive is idle
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    for (int i = 0; i < 2; i++) begin
      if (!arst_n_in || !go_in[i]) cnt_r[i] <= 8'h00;
      else if (ack_in[i]) cnt_r[i] <= cnt_r[i] + 8'h01;
    end
  end
  // Request until done, then interrupt level
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      req_out[i] = go_in[i] && cnt_r[i] < BEATS;
      irq_out[i] = go_in[i] && cnt_r[i] >= BEATS;
    end
  end
endmodule // ibmcc_drive_model

// [tb.sv]
// Testbench: APB command and status sequences on both channels
`timescale 1ns/1ns
module tb;
  import ibmcc_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, rerr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
  logic [1:0] go = 2'h0, irq, req, ack, mrd, mwr, act, abt;
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  ibmcc_top u_ibmcc_top (.CLK_IN(clk), .ARST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .DRIVE_IRQ_IN(irq), .DRIVE_REQ_IN(req), .DRIVE_ACK_OUT(ack), .MEM_RD_OUT(mrd),
    .MEM_WR_OUT(mwr), .ACTIVE_OUT(act), .ABORT_OUT(abt));
  ibmcc_drive_model u_ibmcc_drive_model (.clk_in(clk), .arst_n_in(rst_n), .go_in(go), .ack_in(ack),
    .req_out(req), .irq_out(irq));
  initial forever #5 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk("reg", e, rdat);
  endtask
  task automatic wait_irq(input int i);
    for (int k = 0; k < 60 && irq[i] !== 1'b1; k++) @(posedge clk);
    repeat (3) @(posedge clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Cycle ceiling against hangs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    go[0] <= 1'b1;
    apb(1'b1, IBMCC_PRI_CMD_OFS, 32'hFFFF_FFFF);
    rd(IBMCC_PRI_CMD_OFS, 32'h0000_0009);
    wait_irq(0);
    rd(IBMCC_PRI_STAT_OFS, 32'h0004_0004);
    apb(1'b1, IBMCC_PRI_CMD_OFS, 32'h0000_0009);
    repeat (3) @(posedge clk);
    chk("act", 32'h0000_0000, {30'h0, act});
    apb(1'b1, IBMCC_PRI_STAT_OFS, 32'h0000_0004);
    rd(IBMCC_PRI_STAT_OFS, 32'h0004_0000);
    apb(1'b1, IBMCC_PRI_CMD_OFS, 32'h0000_0008);
    go[0] <= 1'b0;
    rd(IBMCC_PRI_STAT_OFS, 32'h0000_0000);
    apb(1'b1, IBMCC_SEC_CMD_OFS, 32'h0000_0001);
    repeat (3) @(posedge clk);
    chk("act", 32'h0000_0002, {30'h0, act});
    apb(1'b1, IBMCC_SEC_CMD_OFS, 32'h0000_0000);
    rd(IBMCC_SEC_STAT_OFS, 32'h0000_0002);
    apb(1'b1, IBMCC_SEC_CMD_OFS, 32'h0000_0001);
    go[1] <= 1'b1;
    wait_irq(1);
    rd(IBMCC_SEC_STAT_OFS, 32'h0004_0004);
    chk("abt", 32'h0000_0000, {30'h0, abt});
    rd(8'h10, 32'h0000_0000);
    chk("err", 32'h0000_0001, {31'h0, rerr});
    print_verdict();
  end
endmodule // tb
bind ibmcc_top ibmcc_assertions u_ibmcc_assertions (.CLK_IN(CLK_IN), .ARST_N_IN(ARST_N_IN), .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
  .PRDATA_OUT(PRDATA_OUT), .DRIVE_IRQ_IN(DRIVE_IRQ_IN), .DRIVE_REQ_IN(DRIVE_REQ_IN), .DRIVE_ACK_OUT(DRIVE_ACK_OUT),
  .MEM_RD_OUT(MEM_RD_OUT), .MEM_WR_OUT(MEM_WR_OUT), .ACTIVE_OUT(ACTIVE_OUT), .ABORT_OUT(ABORT_OUT));
